// ===== alu_pkg.sv
// Constants, types and register map of the move, reverse and parallel-add datapath slice.
// ============================================================================
// How it works
// - Plain move writes the shifted second operand unchanged into the result.
// - Inverted move writes the bitwise inverse of the second operand.
// - Wide immediate move takes only a 16-bit immediate, unshifted, and never sets flags.
// - Move top writes the immediate into bits 31:16 and keeps the low half.
// - Move top leaves every condition flag unchanged.
// - A plain move into the program counter branches with bit 0 cleared.
// - Stack pointer or counter only in an unshifted, non flag-setting plain move.
// - Flag-setting moves update N and Z, carry from the shift, never V.
// - A shifted plain move gives the same result and flags as the shift.
// - Word byte reverse swaps the four bytes end for end.
// - Halfword byte reverse swaps the bytes inside each halfword.
// - Signed halfword reverse swaps the low bytes and sign extends to 32 bits.
// - Bit reverse puts source bit i into result bit 31 minus i.
// - The four reverse operations leave every condition flag unchanged.
// - Parallel halfword add keeps the low 16 bits of each lane sum.
// - Halfword add sets each greater-equal pair to 11 when its sum is non-negative.
// - Parallel byte add keeps low bytes; each lane flag set when sum non-negative.
// - Add-subtract exchange: low is a.lo minus b.hi, high is a.hi plus b.lo.
// - Subtract-add exchange: low is a.lo plus b.hi, high is a.hi minus b.lo.
// - Byte select picks each result byte from first or second source.
// - A lane flag of one picks the first source; select changes no flags.
// - With no destination given, parallel results also overwrite the first operand.
// - Nothing but the command and status registers changes unless the condition code passes.
package alu_pkg;

  // ==========================================================================
  // Register map.
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_OPA     = 8'h04;
  localparam logic [7:0]  OFS_OPB     = 8'h08;
  localparam logic [7:0]  OFS_OPD     = 8'h0C;
  localparam logic [7:0]  OFS_SHREG   = 8'h10;
  localparam logic [7:0]  OFS_FLAGS   = 8'h14;
  localparam logic [7:0]  OFS_RESULT  = 8'h18;
  localparam logic [7:0]  OFS_STATUS  = 8'h1C;
  localparam logic [7:0]  OFS_BRANCH  = 8'h20;

  // ==========================================================================
  // Command word fields.
  localparam int OP_LSB         = 0;
  localparam int COND_LSB       = 4;
  localparam int SET_FLAGS_BIT  = 8;
  localparam int SHIFT_KIND_LSB = 9;
  localparam int SHIFT_REG_BIT  = 12;
  localparam int SP_PC_BIT      = 13;
  localparam int DEST_PC_BIT    = 14;
  localparam int DEST_OMIT_BIT  = 15;
  localparam int SHIFT_AMT_LSB  = 16;

  // ==========================================================================
  // Flag word fields and status bits.
  localparam int FLAG_N_BIT     = 31;
  localparam int FLAG_Z_BIT     = 30;
  localparam int FLAG_C_BIT     = 29;
  localparam int FLAG_V_BIT     = 28;
  localparam int FLAG_GE_LSB    = 16;
  localparam int ST_DONE_BIT    = 0;
  localparam int ST_FAIL_BIT    = 1;
  localparam int ST_ILLEGAL_BIT = 2;
  localparam int ST_BRANCH_BIT  = 3;

  // ==========================================================================
  // Reset values.
  localparam logic [31:0] RESET_WORD  = 32'h0000_0000;
  localparam logic [3:0]  RESET_NIB   = 4'h0;
  localparam logic [3:0]  COND_ALWAYS = 4'hE;

  // Operation codes.
  typedef enum logic [3:0] {
    OP_PLAIN_MOVE       = 4'b0000,
    OP_INVERTED_MOVE    = 4'b0001,
    OP_WIDE_IMM_MOVE    = 4'b0010,
    OP_MOVE_TOP         = 4'b0011,
    OP_WORD_BYTE_REV    = 4'b0100,
    OP_HALF_BYTE_REV    = 4'b0101,
    OP_SIGNED_HALF_REV  = 4'b0110,
    OP_BIT_REVERSE      = 4'b0111,
    OP_PAR_HALF_ADD     = 4'b1000,
    OP_PAR_BYTE_ADD     = 4'b1001,
    OP_ADD_SUB_EXCHANGE = 4'b1010,
    OP_SUB_ADD_EXCHANGE = 4'b1011,
    OP_BYTE_SELECT      = 4'b1100
  } alu_op_type;

  // Shift kinds applied to the flexible second operand.
  typedef enum logic [2:0] {
    SH_LOGICAL_LEFT  = 3'b000,
    SH_LOGICAL_RIGHT = 3'b001,
    SH_ARITH_RIGHT   = 3'b010,
    SH_ROTATE_RIGHT  = 3'b011,
    SH_ROTATE_EXTEND = 3'b100
  } shift_kind_type;

endpackage : alu_pkg

// ===== shift_if.sv
// Interface carrying the flexible second operand to and from the shifter.
interface shift_if;
  import alu_pkg::*;
  logic [31:0]    value;
  shift_kind_type kind;
  logic [7:0]     amount;
  logic           carry_in;
  logic [31:0]    result;
  logic           carry_out;
  modport client (output value, kind, amount, carry_in, input result, carry_out);
  modport server (input value, kind, amount, carry_in, output result, carry_out);
endinterface : shift_if

// ===== operand_shifter.sv
// Combinational shifter for the flexible second operand, with carry out.
module operand_shifter (
  shift_if.server sh
);
  import alu_pkg::*;

  // ==========================================================================
  // Shift datapath.
  logic [64:0] wide;
  logic [4:0]  rot;

  // Except for rotate extend, a zero amount passes the value and the old carry through untouched.
  always_comb begin
    wide         = 65'h0;
    rot          = sh.amount[4:0];
    sh.result    = sh.value;
    sh.carry_out = sh.carry_in;
    if (sh.kind == SH_ROTATE_EXTEND) begin
      sh.result    = {sh.carry_in, sh.value[31:1]};
      sh.carry_out = sh.value[0];
    end else if (sh.amount != 8'h00) begin
      case (sh.kind)
        SH_LOGICAL_LEFT: begin
          wide         = {33'h0, sh.value} << sh.amount;
          sh.result    = wide[31:0];
          sh.carry_out = wide[32];
        end
        SH_LOGICAL_RIGHT: begin
          wide         = {sh.value, 33'h0} >> sh.amount;
          sh.result    = wide[64:33];
          sh.carry_out = wide[32];
        end
        SH_ARITH_RIGHT: begin
          wide         = 65'($signed({sh.value, 33'h0}) >>> sh.amount);
          sh.result    = wide[64:33];
          sh.carry_out = wide[32];
        end
        SH_ROTATE_RIGHT: begin
          if (rot != 5'h00) begin
            sh.result = (sh.value >> rot) | (sh.value << (6'd32 - {1'b0, rot}));
          end
          sh.carry_out = sh.result[31];
        end
        default: begin
          sh.result    = sh.value;
          sh.carry_out = sh.carry_in;
        end
      endcase
    end
  end

endmodule : operand_shifter

// ===== move_reverse_simd_add_alu.sv
// Move, reverse, parallel add, exchange and byte select datapath with its register port.
module move_reverse_simd_add_alu (
  // Clock and reset.
  input  wire logic                         sys_clk_in,
  input  wire logic                         rst_b_in,
  // Register port.
  input  wire logic [alu_pkg::ADDR_W-1:0]   reg_addr_in,
  input  wire logic [31:0]                  reg_wdata_in,
  input  wire logic                         reg_wr_in,
  input  wire logic                         reg_rd_in,
  output logic      [31:0]                  reg_rdata_out,
  // Branch request towards the fetch logic.
  output logic                              branch_out,
  output logic      [31:0]                  branch_addr_out
);
  import alu_pkg::*;

  // ==========================================================================
  // Helper functions.

  // Signed 16-bit lane add or subtract with the full 17-bit result.
  function automatic logic [16:0] lane16(input logic [15:0] a, input logic [15:0] b, input logic sub);
    lane16 = sub ? ({a[15], a} - {b[15], b}) : ({a[15], a} + {b[15], b});
  endfunction : lane16

  // Signed 8-bit lane add with the full 9-bit result.
  function automatic logic [8:0] lane8(input logic [7:0] a, input logic [7:0] b);
    lane8 = {a[7], a} + {b[7], b};
  endfunction : lane8

  // Condition code evaluation against N, Z, C and V.
  function automatic logic cond_pass(input logic [3:0] cond, input logic [3:0] nzcv);
    logic n;
    logic z;
    logic c;
    logic v;
    n = nzcv[3];
    z = nzcv[2];
    c = nzcv[1];
    v = nzcv[0];
    case (cond)
      4'h0:    cond_pass = z;
      4'h1:    cond_pass = !z;
      4'h2:    cond_pass = c;
      4'h3:    cond_pass = !c;
      4'h4:    cond_pass = n;
      4'h5:    cond_pass = !n;
      4'h6:    cond_pass = v;
      4'h7:    cond_pass = !v;
      4'h8:    cond_pass = c && !z;
      4'h9:    cond_pass = !c || z;
      4'hA:    cond_pass = n == v;
      4'hB:    cond_pass = n != v;
      4'hC:    cond_pass = !z && (n == v);
      4'hD:    cond_pass = z || (n != v);
      default: cond_pass = 1'b1;
    endcase
  endfunction : cond_pass

  // ==========================================================================
  // Registers.
  logic [31:0] ctrl;
  logic [31:0] opa;
  logic [31:0] opb;
  logic [31:0] opd;
  logic [31:0] shreg;
  logic [3:0]  nzcv;
  logic [3:0]  ge;
  logic [31:0] result;
  logic [3:0]  status;

  // ==========================================================================
  // Command decode; writing the command word executes it in the same cycle.
  logic           exec;
  alu_op_type     op;
  logic [3:0]     cond;
  logic           set_flags;
  logic           shift_by_reg;
  logic           sp_pc;
  logic           dest_pc;
  logic           dest_omit;
  logic [5:0]     shift_amt;
  logic           shift_none;
  logic           passed;
  logic           parallel_op;

  assign exec         = reg_wr_in && (reg_addr_in == OFS_CTRL);
  assign op           = alu_op_type'(reg_wdata_in[OP_LSB +: 4]);
  assign cond         = reg_wdata_in[COND_LSB +: 4];
  assign set_flags    = reg_wdata_in[SET_FLAGS_BIT];
  assign shift_by_reg = reg_wdata_in[SHIFT_REG_BIT];
  assign sp_pc        = reg_wdata_in[SP_PC_BIT] || reg_wdata_in[DEST_PC_BIT];
  assign dest_pc      = reg_wdata_in[DEST_PC_BIT];
  assign dest_omit    = reg_wdata_in[DEST_OMIT_BIT];
  assign shift_amt    = reg_wdata_in[SHIFT_AMT_LSB +: 6];
  assign shift_none   = !shift_by_reg && (reg_wdata_in[SHIFT_KIND_LSB +: 3] == SH_LOGICAL_LEFT) && (shift_amt == 6'h00);
  assign passed       = cond_pass(cond, nzcv);
  assign parallel_op  = (op == OP_PAR_HALF_ADD) || (op == OP_PAR_BYTE_ADD) ||
                        (op == OP_ADD_SUB_EXCHANGE) || (op == OP_SUB_ADD_EXCHANGE) || (op == OP_BYTE_SELECT);

  // ==========================================================================
  // Flexible second operand shifter; amount by register uses the bottom byte.
  shift_if sh ();

  assign sh.value    = opb;
  assign sh.kind     = shift_kind_type'(reg_wdata_in[SHIFT_KIND_LSB +: 3]);
  assign sh.amount   = shift_by_reg ? shreg[7:0] : {2'b00, shift_amt};
  assign sh.carry_in = nzcv[1];

  operand_shifter shifter_inst (
    .sh (sh.server)
  );

  // ==========================================================================
  // Operation datapath.
  logic [31:0] next_result;
  logic [3:0]  next_nzcv;
  logic [3:0]  next_ge;
  logic        illegal;
  logic [16:0] s_lo;
  logic [16:0] s_hi;
  logic [8:0]  s_b [4];

  // Computes the result and the flags that the executed operation would leave.
  always_comb begin
    next_result = RESET_WORD;
    next_nzcv   = nzcv;
    next_ge     = ge;
    illegal     = 1'b0;
    s_lo        = 17'h0;
    s_hi        = 17'h0;
    for (int i = 0; i < 4; i++) begin
      s_b[i] = lane8(opa[8*i +: 8], opb[8*i +: 8]);
    end
    case (op)
      OP_PLAIN_MOVE, OP_INVERTED_MOVE: begin
        next_result = (op == OP_INVERTED_MOVE) ? ~sh.result : sh.result;
        if (set_flags) begin
          next_nzcv = {next_result[31], next_result == 32'h0, sh.carry_out, nzcv[0]};
        end
      end
      OP_WIDE_IMM_MOVE: begin
        next_result = {16'h0000, opb[15:0]};
        illegal     = opb[31:16] != 16'h0000;
      end
      OP_MOVE_TOP: begin
        next_result = {opb[15:0], opd[15:0]};
      end
      OP_WORD_BYTE_REV: begin
        next_result = {opa[7:0], opa[15:8], opa[23:16], opa[31:24]};
      end
      OP_HALF_BYTE_REV: begin
        next_result = {opa[23:16], opa[31:24], opa[7:0], opa[15:8]};
      end
      OP_SIGNED_HALF_REV: begin
        next_result = {{16{opa[7]}}, opa[7:0], opa[15:8]};
      end
      OP_BIT_REVERSE: begin
        for (int i = 0; i < 32; i++) begin
          next_result[31-i] = opa[i];
        end
      end
      OP_PAR_HALF_ADD, OP_ADD_SUB_EXCHANGE, OP_SUB_ADD_EXCHANGE: begin
        if (op == OP_PAR_HALF_ADD) begin
          s_lo = lane16(opa[15:0], opb[15:0], 1'b0);
          s_hi = lane16(opa[31:16], opb[31:16], 1'b0);
        end else if (op == OP_ADD_SUB_EXCHANGE) begin
          s_lo = lane16(opa[15:0], opb[31:16], 1'b1);
          s_hi = lane16(opa[31:16], opb[15:0], 1'b0);
        end else begin
          s_lo = lane16(opa[15:0], opb[31:16], 1'b0);
          s_hi = lane16(opa[31:16], opb[15:0], 1'b1);
        end
        next_result = {s_hi[15:0], s_lo[15:0]};
        next_ge     = {{2{!s_hi[16]}}, {2{!s_lo[16]}}};
      end
      OP_PAR_BYTE_ADD: begin
        for (int i = 0; i < 4; i++) begin
          next_result[8*i +: 8] = s_b[i][7:0];
          next_ge[i]            = !s_b[i][8];
        end
      end
      OP_BYTE_SELECT: begin
        for (int i = 0; i < 4; i++) begin
          next_result[8*i +: 8] = ge[i] ? opa[8*i +: 8] : opb[8*i +: 8];
        end
      end
      default: begin
        illegal = 1'b1;
      end
    endcase
    // Stack pointer and counter are only taken by an unshifted plain move without flags.
    if (sp_pc && !((op == OP_PLAIN_MOVE) && shift_none && !set_flags)) begin
      illegal = 1'b1;
    end
  end

  logic commit;
  assign commit = exec && passed && !illegal;

  // ==========================================================================
  // Command word and status capture.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl   <= RESET_WORD;
      status <= RESET_NIB;
    end else if (exec) begin
      ctrl                   <= reg_wdata_in;
      status[ST_DONE_BIT]    <= commit;
      status[ST_FAIL_BIT]    <= !passed;
      status[ST_ILLEGAL_BIT] <= passed && illegal;
      status[ST_BRANCH_BIT]  <= commit && dest_pc;
    end
  end

  // First operand; also the destination when none is encoded for parallel operations.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      opa <= RESET_WORD;
    end else if (commit && dest_omit && parallel_op) begin
      opa <= next_result;
    end else if (reg_wr_in && (reg_addr_in == OFS_OPA)) begin
      opa <= reg_wdata_in;
    end
  end

  // Other operand registers written only by software.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      opb   <= RESET_WORD;
      opd   <= RESET_WORD;
      shreg <= RESET_WORD;
    end else if (reg_wr_in) begin
      if (reg_addr_in == OFS_OPB) begin
        opb <= reg_wdata_in;
      end else if (reg_addr_in == OFS_OPD) begin
        opd <= reg_wdata_in;
      end else if (reg_addr_in == OFS_SHREG) begin
        shreg <= reg_wdata_in;
      end
    end
  end

  // Status flags; software may load them, an executed operation updates them.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      nzcv <= RESET_NIB;
      ge   <= RESET_NIB;
    end else if (commit) begin
      nzcv <= next_nzcv;
      ge   <= next_ge;
    end else if (reg_wr_in && (reg_addr_in == OFS_FLAGS)) begin
      nzcv <= reg_wdata_in[FLAG_V_BIT +: 4];
      ge   <= reg_wdata_in[FLAG_GE_LSB +: 4];
    end
  end

  // Result register and branch request; a move into the counter drops bit 0.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      result          <= RESET_WORD;
      branch_out      <= 1'b0;
      branch_addr_out <= RESET_WORD;
    end else begin
      branch_out <= commit && dest_pc;
      if (commit) begin
        result <= next_result;
        if (dest_pc) begin
          branch_addr_out <= {next_result[31:1], 1'b0};
        end
      end
    end
  end

  // ==========================================================================
  // Read data stand only in the cycle after the read strobe; unmapped reads zero.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= RESET_WORD;
    end else if (!reg_rd_in) begin
      reg_rdata_out <= RESET_WORD;
    end else if (reg_addr_in == OFS_CTRL) begin
      reg_rdata_out <= ctrl;
    end else if (reg_addr_in == OFS_OPA) begin
      reg_rdata_out <= opa;
    end else if (reg_addr_in == OFS_OPB) begin
      reg_rdata_out <= opb;
    end else if (reg_addr_in == OFS_OPD) begin
      reg_rdata_out <= opd;
    end else if (reg_addr_in == OFS_SHREG) begin
      reg_rdata_out <= shreg;
    end else if (reg_addr_in == OFS_FLAGS) begin
      reg_rdata_out <= {nzcv, 8'h00, ge, 16'h0000};
    end else if (reg_addr_in == OFS_RESULT) begin
      reg_rdata_out <= result;
    end else if (reg_addr_in == OFS_STATUS) begin
      reg_rdata_out <= {28'h0000000, status};
    end else if (reg_addr_in == OFS_BRANCH) begin
      reg_rdata_out <= branch_addr_out;
    end else begin
      reg_rdata_out <= RESET_WORD;
    end
  end

  // ==========================================================================
  // Checks on the executed operations.
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);

  AST_INVERTED_MOVE: assert property (
    commit && (op == OP_INVERTED_MOVE) && shift_none |=> result == ~$past(opb)
  ) else $error("Inverted move result is not the inverse of the operand.");

  AST_WIDE_IMM_LIMIT: assert property (
    exec && passed && (op == OP_WIDE_IMM_MOVE) && (opb[31:16] != 16'h0000) |=> status[ST_ILLEGAL_BIT] && $stable(result)
  ) else $error("Wide immediate above sixteen bits was not refused.");

  AST_MOVE_TOP_HALF: assert property (
    commit && (op == OP_MOVE_TOP) |=> (result[31:16] == $past(opb[15:0])) && (result[15:0] == $past(opd[15:0]))
  ) else $error("Move top did not keep the low halfword.");

  AST_FLAGS_KEPT: assert property (
    exec && ((op == OP_MOVE_TOP) || (op[3:2] == 2'b01)) |=> $stable(nzcv) && $stable(ge)
  ) else $error("Move top or reverse altered a flag.");

  AST_BRANCH_BIT0: assert property (
    commit && dest_pc |=> branch_out && (branch_addr_out == {$past(opb[31:1]), 1'b0}) ##1 (!branch_out || $past(exec))
  ) else $error("Branch address or pulse wrong after move into the counter.");

  AST_SP_PC_FLAGS: assert property (
    exec && passed && sp_pc && set_flags |=> status[ST_ILLEGAL_BIT] && $stable(nzcv) && !branch_out
  ) else $error("Flag-setting move with stack pointer or counter was accepted.");

  AST_MOVE_V_KEPT: assert property (
    commit && (op == OP_PLAIN_MOVE) && set_flags |=> (nzcv[0] == $past(nzcv[0])) && (nzcv[2] == (result == 32'h0))
  ) else $error("Flag-setting move disturbed overflow or zero.");

  AST_WORD_REVERSE: assert property (
    commit && (op == OP_WORD_BYTE_REV) |=> (result[31:24] == $past(opa[7:0])) && (result[7:0] == $past(opa[31:24]))
  ) else $error("Word byte reverse placed bytes wrongly.");

  AST_BIT_REVERSE: assert property (
    commit && (op == OP_BIT_REVERSE) |=> (result[31] == $past(opa[0])) && (result[0] == $past(opa[31]))
  ) else $error("Bit reverse did not mirror the word.");

  AST_HALF_ADD_GE: assert property (
    commit && (op == OP_PAR_HALF_ADD) |=> (ge[1:0] == {2{$signed($past(opa[15:0])) + $signed($past(opb[15:0])) >= 0}}) &&
      (ge[3] == ge[2]) && $stable(nzcv)
  ) else $error("Halfword add greater-equal pair wrong.");

  AST_SELECT_LANE: assert property (
    commit && (op == OP_BYTE_SELECT) && !dest_omit |=> (result[7:0] == ($past(ge[0]) ? $past(opa[7:0]) : $past(opb[7:0]))) && $stable(ge)
  ) else $error("Byte select took the wrong source.");

  AST_COND_FAIL: assert property (
    exec && !passed |=> $stable(result) && $stable(nzcv) && $stable(ge) && status[ST_FAIL_BIT] && !branch_out
  ) else $error("Failed condition still changed state.");

endmodule : move_reverse_simd_add_alu

// ===== far_side_model.sv
// Fetch-side model that records the branch requests of the datapath.
module far_side_model (
  // Clock and reset.
  input  wire logic        sys_clk_in,
  input  wire logic        rst_b_in,
  // Branch request from the datapath.
  input  wire logic        branch_in,
  input  wire logic [31:0] target_in,
  // What the fetch side has seen.
  output int               taken_out,
  output logic      [31:0] last_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Counts each branch pulse and keeps its target, as a fetch unit would.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      taken_out <= 0;
      last_out  <= 32'h0;
    end else if (branch_in) begin
      taken_out <= taken_out + 1;
      last_out  <= target_in;
    end
  end
endmodule : far_side_model

// ===== testbench.sv
// Self-checking testbench of the move, reverse and parallel-add datapath.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import alu_pkg::*;
  logic        clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, br;
  logic [7:0]  ad = 8'h00;
  logic [31:0] wd = 32'h0, rdat, badr, last, got, lastres, b;
  logic [3:0]  op, k;
  int          err_total = 0, cmp_count = 0, taken, sh;
  // The clock toggles every 2 ns, a period of 4 ns.
  always #2 clk = ~clk;
  move_reverse_simd_add_alu i_dut (.sys_clk_in(clk), .rst_b_in(rst_b), .reg_addr_in(ad), .reg_wdata_in(wd),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat), .branch_out(br), .branch_addr_out(badr));
  far_side_model i_far (.sys_clk_in(clk), .rst_b_in(rst_b), .branch_in(br), .target_in(badr),
    .taken_out(taken), .last_out(last));
  // ==========================================================================
  // Bus tasks and the reference model.
  task automatic check(input string nm, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  // A write leaves its strobe high so that writes may follow back to back.
  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    ad <= a;
    wd <= d;
    wr <= 1'b1;
    rd <= 1'b0;
  endtask : wrr
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    ad <= a;
    rd <= 1'b1;
    wr <= 1'b0;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdat;
  endtask : rdr
  function automatic logic [16:0] hs(input logic [15:0] x, y, input logic sub);
    return sub ? {x[15], x} - {y[15], y} : {x[15], x} + {y[15], y};
  endfunction : hs
  // Shifts the flexible second operand and returns the carry above the value.
  function automatic logic [32:0] shf(input logic [2:0] k, input logic [31:0] v, input int n, input logic ci);
    logic [63:0] w;
    w = {v, v};
    if (k == 3'h4) return {v[0], ci, v[31:1]};
    if (n == 0) return {ci, v};
    case (k)
      3'h0: return {v[32-n], v << n};
      3'h1: return {v[n-1], v >> n};
      3'h2: return {v[n-1], 32'($signed(v) >>> n)};
      default: return {v[n-1], w[n+:32]};
    endcase
  endfunction : shf
  // Returns the new lane flags above the 32-bit result.
  function automatic logic [35:0] model(input logic [3:0] o, input logic [31:0] a, b, d, input logic [3:0] g);
    logic [16:0] lo, hi;
    logic [8:0]  y;
    logic [31:0] r;
    logic [3:0]  ge;
    ge = g;
    r = 32'h0;
    case (o)
      4'h0: r = b;
      4'h1: r = ~b;
      4'h2: r = b;
      4'h3: r = {b[15:0], d[15:0]};
      4'h4: r = {a[7:0], a[15:8], a[23:16], a[31:24]};
      4'h5: r = {a[23:16], a[31:24], a[7:0], a[15:8]};
      4'h6: r = {{16{a[7]}}, a[7:0], a[15:8]};
      4'h7: for (int i = 0; i < 32; i++) r[i] = a[31-i];
      4'h8: {hi, lo} = {hs(a[31:16], b[31:16], 1'b0), hs(a[15:0], b[15:0], 1'b0)};
      4'hA: {hi, lo} = {hs(a[31:16], b[15:0], 1'b0), hs(a[15:0], b[31:16], 1'b1)};
      4'hB: {hi, lo} = {hs(a[31:16], b[15:0], 1'b1), hs(a[15:0], b[31:16], 1'b0)};
      4'h9: for (int i = 0; i < 4; i++) begin
        y = {a[8*i+7], a[8*i+:8]} + {b[8*i+7], b[8*i+:8]};
        r[8*i+:8] = y[7:0];
        ge[i] = ~y[8];
      end
      default: for (int i = 0; i < 4; i++) r[8*i+:8] = g[i] ? a[8*i+:8] : b[8*i+:8];
    endcase
    if (o inside {4'h8, 4'hA, 4'hB}) begin
      r = {hi[15:0], lo[15:0]};
      ge = {{2{~hi[16]}}, {2{~lo[16]}}};
    end
    return {ge, r};
  endfunction : model
  // Loads operands and flags, executes one command and checks result, flags and first operand.
  task automatic run(input logic [3:0] o, input logic [31:0] a, bb, d, f, input int n, input logic [3:0] k,
                     input logic s, om);
    logic [35:0] m;
    logic [31:0] ef;
    logic [32:0] t;
    t = shf(k[2:0], bb, n, f[29]);
    m = model(o, a, (o < 4'h2) ? t[31:0] : bb, d, f[19:16]);
    ef = f;
    lastres = m[31:0];
    if (o inside {[4'h8:4'hB]}) ef[19:16] = m[35:32];
    if (s) ef[31:29] = {m[31], m[31:0] == 32'h0, t[32]};
    wrr(OFS_SHREG, n);
    wrr(OFS_OPA, a);
    wrr(OFS_OPB, bb);
    wrr(OFS_OPD, d);
    wrr(OFS_FLAGS, f);
    wrr(OFS_CTRL, {10'h0, k[3] ? 6'h0 : n[5:0], om, 2'h0, k, s, COND_ALWAYS, o});
    rdr(OFS_RESULT);
    check("result", got, m[31:0]);
    rdr(OFS_FLAGS);
    check("flags", got, ef);
    rdr(OFS_OPA);
    check("first operand", got, om ? m[31:0] : a);
  endtask : run
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  // ==========================================================================
  // Test sequence.
  initial begin
    void'($urandom(32'h45d0f00f));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    run(4'h8, 32'h7FFF8000, 32'h00018000, 32'h0, 32'hF0000000, 0, 4'h0, 1'b0, 1'b1);
    run(4'h9, 32'h807F7F01, 32'h80017FFF, 32'h0, 32'h0, 0, 4'h0, 1'b0, 1'b1);
    run(4'hC, 32'h11223344, 32'hAABBCCDD, 32'h0, 32'h00050000, 0, 4'h0, 1'b0, 1'b0);
    run(4'h0, 32'h0, 32'h80000001, 32'h0, 32'h10000000, 1, 4'h0, 1'b1, 1'b0);
    $display("Corner test finished.");
    repeat (60) begin
      op = 4'($urandom % 13);
      sh = (op < 4'h2) ? int'($urandom % 32) : 0;
      k = (op < 4'h2) ? {1'($urandom), 3'($urandom % 5)} : 4'h0;
      b = $urandom;
      if (op == 4'h2) b[31:16] = 16'h0;
      run(op, $urandom, b, $urandom, $urandom & 32'hF00F0000, sh, k, (op < 2) ? 1'($urandom) : 1'b0,
          (op > 7) ? 1'($urandom) : 1'b0);
    end
    $display("Random test finished.");
    wrr(OFS_FLAGS, 32'h0);
    wrr(OFS_CTRL, 32'h00000001);
    rdr(OFS_STATUS);
    check("status", got, 32'h2);
    rdr(OFS_RESULT);
    check("result", got, lastres);
    wrr(OFS_CTRL, 32'h000021E0);
    rdr(OFS_STATUS);
    check("status", got, 32'h4);
    wrr(OFS_OPB, 32'h80001235);
    wrr(OFS_CTRL, 32'h000000E2);
    rdr(OFS_STATUS);
    check("status", got, 32'h4);
    wrr(OFS_OPB, 32'h00001235);
    wrr(OFS_CTRL, 32'h000040E0);
    @(posedge clk);
    wr <= 1'b0;
    #1 check("branch", {31'h0, br}, 32'h1);
    check("target", badr, 32'h00001234);
    rdr(8'h40);
    check("unmapped", got, 32'h0);
    check("fetch", last, 32'h00001234);
    check("taken", 32'(taken), 32'h1);
    $display("Directed test finished.");
    end_of_test;
  end
  // Cuts a hang short well after the expected run time.
  initial begin
    #100000;
    err_total++;
    end_of_test;
  end
endmodule : testbench
